//--- tmr_defines.svh
// Purpose: Register indexes, field positions and reset values of the timer
// Assumes: Included by bare name wherever the map is needed
// Notes:   Byte address of a register is four times its index
`ifndef TMR_DEFINES_SVH
`define TMR_DEFINES_SVH

`define TMR_ADDR_LSB     2
`define TMR_IDX_CTRL_B   8'h31
`define TMR_IDX_CTRL_A   8'h32
`define TMR_IDX_STATUS   8'h33
`define TMR_IDX_CAPA_HI  8'h34
`define TMR_IDX_CAPA_LO  8'h35
`define TMR_IDX_CMPA_HI  8'h36
`define TMR_IDX_CMPA_LO  8'h37
`define TMR_IDX_CNT_HI   8'h38
`define TMR_IDX_CNT_LO   8'h39
`define TMR_IDX_ALT_HI   8'h3A
`define TMR_IDX_ALT_LO   8'h3B
`define TMR_IDX_CAPB_HI  8'h3C
`define TMR_IDX_CAPB_LO  8'h3D
`define TMR_IDX_CMPB_HI  8'h3E
`define TMR_IDX_CMPB_LO  8'h3F

`define TMR_CA_CAP_IE    7
`define TMR_CA_CMP_IE    6
`define TMR_CA_OVF_IE    5
`define TMR_CA_FORCE_B   4
`define TMR_CA_FORCE_A   3
`define TMR_CA_LVL_B     2
`define TMR_CA_EDGE_A    1
`define TMR_CA_LVL_A     0

`define TMR_CB_PIN_A     7
`define TMR_CB_PIN_B     6
`define TMR_CB_PULSE     5
`define TMR_CB_PWM       4
`define TMR_CB_CLK_HI    3
`define TMR_CB_CLK_LO    2
`define TMR_CB_EDGE_B    1
`define TMR_CB_EXT_EDGE  0

`define TMR_ST_FREEZE    2
`define TMR_FLAG_CAP_A   4
`define TMR_FLAG_CMP_A   3
`define TMR_FLAG_OVF     2
`define TMR_FLAG_CAP_B   1
`define TMR_FLAG_CMP_B   0

`define TMR_CTRL_RESET   8'h00
`define TMR_CNT_RESET    16'hFFFC
`define TMR_CNT_MAX      16'hFFFF
`define TMR_CMP_RESET    16'h8000
`endif

//--- tmr_pkg.sv
// Purpose: Shared types of the timer control block
// Assumes: Nothing
// Notes:   Mode codes are one-hot
package tmr_pkg;
  typedef enum logic [2:0] {
    TMR_MODE_CMP   = 3'b001,
    TMR_MODE_PULSE = 3'b010,
    TMR_MODE_PWM   = 3'b100
  } tmr_mode_e;

  typedef enum logic [1:0] {
    TMR_CLK_DIV4 = 2'b00,
    TMR_CLK_DIV2 = 2'b01,
    TMR_CLK_DIV8 = 2'b10,
    TMR_CLK_EXT  = 2'b11
  } tmr_clk_e;

  typedef struct packed {
    logic [7:0]  ctrl_a;
    logic [7:0]  ctrl_b;
    logic [4:0]  flags;
    logic [4:0]  armed;
    logic        freeze;
    logic [15:0] count;
    logic [15:0] cmp_a;
    logic [15:0] cmp_b;
    logic [15:0] cap_a;
    logic [15:0] cap_b;
    logic        out_a;
    logic        out_b;
    logic        wr_pend;
    logic [7:0]  wr_idx;
    logic [7:0]  rdata;
  } tmr_state_s;
endpackage

//--- tmr_edge.sv
// Purpose: Edge detection on capture and count-clock pins
// Assumes: Inputs synchronous to clock
// Notes:   First cycle after reset only primes the history
`timescale 1ns/1ps
module tmr_edge #(
  parameter int N = 3
)
(
  input  wire logic         clock,
  input  wire logic         reset_n,
  input  wire logic [N-1:0] level,
  input  wire logic [N-1:0] rising,
  output logic      [N-1:0] pulse
);
  typedef struct packed {
    logic         primed;
    logic [N-1:0] prev;
  } tmr_edge_s;

  tmr_edge_s st;
  tmr_edge_s next_st;

  always_comb
  begin
    next_st        = st;
    next_st.primed = 1'b1;
    next_st.prev   = level;
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      st <= '0;
    else
      st <= next_st;
  end

  for (genvar i = 0; i < N; i++)
  begin : g_pin
    assign pulse[i] = st.primed &&
                      (rising[i] ? (level[i] && !st.prev[i])
                                 : (!level[i] && st.prev[i]));
  end

  //////////////////////////////////////////////////////////////////////////
  edge_a_sel_a:
    assert property (@(posedge clock) disable iff (!reset_n)
      pulse[0] |-> (level[0] == rising[0]) && (st.prev[0] != level[0]))
    else $error("capture edge A fired on wrong transition");

  edge_b_sel_a:
    assert property (@(posedge clock) disable iff (!reset_n)
      pulse[1] |-> (level[1] == rising[1]) && (st.prev[1] != level[1]))
    else $error("capture edge B fired on wrong transition");
endmodule

//--- tmr_prescale.sv
// Purpose: Counter tick from a divided clock or external edge
// Assumes: ext_edge is a one-cycle pulse
// Notes:   Divider holds while run is low
`timescale 1ns/1ps
module tmr_prescale #(
  parameter bit EXT_PRESENT = 1'b1
)
(
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic [1:0] clock_select,
  input  wire logic       run,
  input  wire logic       ext_edge,
  output logic            tick
);
  typedef struct packed {
    logic [2:0] div;
  } tmr_pre_s;

  tmr_pre_s st;
  tmr_pre_s next_st;

  always_comb
  begin
    next_st = st;
    if (run)
      next_st.div = st.div + 3'h1;
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      st <= '0;
    else
      st <= next_st;
  end

  always_comb
  begin
    case (tmr_pkg::tmr_clk_e'(clock_select))
      tmr_pkg::TMR_CLK_DIV4: tick = run && (st.div[1:0] == 2'h3);
      tmr_pkg::TMR_CLK_DIV2: tick = run && st.div[0];
      tmr_pkg::TMR_CLK_DIV8: tick = run && (st.div == 3'h7);
      tmr_pkg::TMR_CLK_EXT:  tick = run && EXT_PRESENT && ext_edge;
      default:               tick = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  div2_rate_a:
    assert property (@(posedge clock) disable iff (!reset_n)
      (tick && clock_select == 2'h1) |=> !tick || clock_select != 2'h1)
    else $error("divide-by-two tick on consecutive cycles");

  ext_absent_a:
    assert property (@(posedge clock) disable iff (!reset_n)
      (!EXT_PRESENT && clock_select == 2'h3) |-> !tick)
    else $error("counter ticked with no external clock pin");
endmodule

//--- tmr_ctrl.sv
// Purpose: 16-bit capture/compare timer with AHB-Lite register access
// Assumes: Pins synchronous to clock; master leaves one idle between
//          a write and the next transfer
// Notes:   Zero wait states; read side effects act in the address phase
//
// Chosen here: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`include "tmr_defines.svh"

// Functional notes
// - All events share one masked interrupt line
// - Events wake from wait, never halt
// - Capture enable gates capture flag interrupts
// - Compare enable gates compare flag interrupts
// - Overflow enable gates overflow interrupt
// - Force bits copy levels to pins
// - Compare B match drives level B in compare mode
// - Capture A edge polarity select
// - Compare A match drives level A
// - Pin enables only route outputs
// - Single pulse triggered by capture A
// - PWM: width compare A, period B
// - Clock select chooses divider or external
// - Absent external pin stops counter
// - Capture B edge polarity select
// - External clock edge polarity select
// - Capture A flag set, cleared
// - Compare A flag set, cleared
// - Overflow flag; alternate read keeps it
// - Capture B, compare B flags
// - Freeze stops counting, disables pins
// - PWM blocks compare flags
// - PWM period reloads counter FFFC
// - PWM overrides single pulse mode
// - Counter low write resets counter
module tmr_ctrl #(
  parameter bit EXT_PRESENT = 1'b1
)
(
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        capture_in_a,
  input  wire logic        capture_in_b,
  input  wire logic        ext_count_clock,
  input  wire logic        cpu_irq_mask,
  input  wire logic        halt_mode,
  output logic             compare_out_a,
  output logic             compare_out_a_en,
  output logic             compare_out_b,
  output logic             compare_out_b_en,
  output logic             timer_irq,
  output logic             wake_req
);
  localparam tmr_pkg::tmr_state_s ST_RESET = '{
    ctrl_a:  `TMR_CTRL_RESET,
    ctrl_b:  `TMR_CTRL_RESET,
    flags:   5'h00,
    armed:   5'h00,
    freeze:  1'b0,
    count:   `TMR_CNT_RESET,
    cmp_a:   `TMR_CMP_RESET,
    cmp_b:   `TMR_CMP_RESET,
    cap_a:   16'h0000,
    cap_b:   16'h0000,
    out_a:   1'b0,
    out_b:   1'b0,
    wr_pend: 1'b0,
    wr_idx:  8'h00,
    rdata:   8'h00
  };

  tmr_pkg::tmr_state_s st;
  tmr_pkg::tmr_state_s next_st;
  tmr_pkg::tmr_mode_e  mode;

  logic [2:0]  edge_pulse;
  logic        tick;
  logic        run;
  logic [15:0] inc;
  logic        ovf_ev;
  logic        match_a;
  logic        match_b;
  logic        cap_a_ev;
  logic        cap_b_ev;
  logic        period_start;
  logic        addr_ok;
  logic        rd_go;
  logic [7:0]  idx;
  logic [7:0]  wbyte;
  logic        cnt_wr;
  logic        status_rd;
  logic [4:0]  acc_lo;
  logic [4:0]  flag_set;
  logic [4:0]  flag_clr;
  logic        irq_pend;

  //////////////////////////////////////////////////////////////////////////
  // Pin edges and count clock

  tmr_edge #(
    .N (3)
  ) u_edge (
    .clock   (clock),
    .reset_n (reset_n),
    .level   ({ext_count_clock, capture_in_b, capture_in_a}),
    .rising  ({st.ctrl_b[`TMR_CB_EXT_EDGE], st.ctrl_b[`TMR_CB_EDGE_B],
               st.ctrl_a[`TMR_CA_EDGE_A]}),
    .pulse   (edge_pulse)
  );

  assign run = !st.freeze && !halt_mode;

  tmr_prescale #(
    .EXT_PRESENT (EXT_PRESENT)
  ) u_prescale (
    .clock        (clock),
    .reset_n      (reset_n),
    .clock_select (st.ctrl_b[`TMR_CB_CLK_HI:`TMR_CB_CLK_LO]),
    .run          (run),
    .ext_edge     (edge_pulse[2]),
    .tick         (tick)
  );

  //////////////////////////////////////////////////////////////////////////
  // Mode and timer events

  always_comb
  begin
    if (st.ctrl_b[`TMR_CB_PWM])
      mode = tmr_pkg::TMR_MODE_PWM;
    else if (st.ctrl_b[`TMR_CB_PULSE])
      mode = tmr_pkg::TMR_MODE_PULSE;
    else
      mode = tmr_pkg::TMR_MODE_CMP;
  end

  assign inc     = st.count + 16'h0001;
  assign ovf_ev  = tick && (st.count == `TMR_CNT_MAX);
  assign match_a = tick && (inc == st.cmp_a);
  assign match_b = tick && (inc == st.cmp_b);
  // Capture pin A is disconnected from the timer in PWM mode
  assign cap_a_ev = edge_pulse[0] && (mode != tmr_pkg::TMR_MODE_PWM);
  assign cap_b_ev = edge_pulse[1];
  assign period_start =
    (cap_a_ev && (mode == tmr_pkg::TMR_MODE_PULSE)) ||
    (match_b && (mode == tmr_pkg::TMR_MODE_PWM));

  //////////////////////////////////////////////////////////////////////////
  // Bus decode

  assign addr_ok   = hsel && htrans[1] && hready;
  assign idx       = haddr[`TMR_ADDR_LSB+7:`TMR_ADDR_LSB];
  assign rd_go     = addr_ok && !hwrite;
  assign wbyte     = hwdata[7:0];
  assign status_rd = rd_go && (idx == `TMR_IDX_STATUS);
  assign cnt_wr    = st.wr_pend && (st.wr_idx == `TMR_IDX_CNT_LO);

  function automatic logic lo_hit(input logic [7:0] x);
    lo_hit = (rd_go && (idx == x)) || (st.wr_pend && (st.wr_idx == x));
  endfunction
  always_comb
  begin
    // only the main low byte clears overflow
    acc_lo[`TMR_FLAG_CAP_A] = lo_hit(`TMR_IDX_CAPA_LO);
    acc_lo[`TMR_FLAG_CMP_A] = lo_hit(`TMR_IDX_CMPA_LO);
    acc_lo[`TMR_FLAG_OVF]   = lo_hit(`TMR_IDX_CNT_LO);
    acc_lo[`TMR_FLAG_CAP_B] = lo_hit(`TMR_IDX_CAPB_LO);
    acc_lo[`TMR_FLAG_CMP_B] = lo_hit(`TMR_IDX_CMPB_LO);
  end
  function automatic logic [7:0] rd_mux(input logic [7:0] a);
    case (a)
      `TMR_IDX_CTRL_A:  rd_mux = st.ctrl_a;
      `TMR_IDX_CTRL_B:  rd_mux = st.ctrl_b;
      `TMR_IDX_STATUS:  rd_mux = {st.flags, st.freeze, 2'b00};
      `TMR_IDX_CAPA_HI: rd_mux = st.cap_a[15:8];
      `TMR_IDX_CAPA_LO: rd_mux = st.cap_a[7:0];
      `TMR_IDX_CMPA_HI: rd_mux = st.cmp_a[15:8];
      `TMR_IDX_CMPA_LO: rd_mux = st.cmp_a[7:0];
      `TMR_IDX_CNT_HI:  rd_mux = st.count[15:8];
      `TMR_IDX_CNT_LO:  rd_mux = st.count[7:0];
      `TMR_IDX_ALT_HI:  rd_mux = st.count[15:8];
      `TMR_IDX_ALT_LO:  rd_mux = st.count[7:0];
      `TMR_IDX_CAPB_HI: rd_mux = st.cap_b[15:8];
      `TMR_IDX_CAPB_LO: rd_mux = st.cap_b[7:0];
      `TMR_IDX_CMPB_HI: rd_mux = st.cmp_b[15:8];
      `TMR_IDX_CMPB_LO: rd_mux = st.cmp_b[7:0];
      default:          rd_mux = 8'h00;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Event flags

  assign flag_set[`TMR_FLAG_CAP_A] = cap_a_ev ||
    (match_b && (mode == tmr_pkg::TMR_MODE_PWM));
  // no compare A flag in pulse modes
  assign flag_set[`TMR_FLAG_CMP_A] = match_a &&
    (mode == tmr_pkg::TMR_MODE_CMP);
  assign flag_set[`TMR_FLAG_OVF]   = ovf_ev;
  assign flag_set[`TMR_FLAG_CAP_B] = cap_b_ev;
  assign flag_set[`TMR_FLAG_CMP_B] = match_b &&
    (mode != tmr_pkg::TMR_MODE_PWM);
  assign flag_clr = st.armed & acc_lo;

  //////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    next_st = st;
    // Set wins over a clear landing in the same cycle
    next_st.flags = (st.flags & ~flag_clr) | flag_set;
    if (status_rd)
      next_st.armed = st.flags;
    else
      next_st.armed = st.armed & ~acc_lo;

    if (cnt_wr || period_start)
      next_st.count = `TMR_CNT_RESET;
    else if (tick)
      next_st.count = inc;

    if (cap_a_ev)
      next_st.cap_a = st.count;
    if (cap_b_ev)
      next_st.cap_b = st.count;

    // level A on match or force
    if (match_a || st.ctrl_a[`TMR_CA_FORCE_A])
      next_st.out_a = st.ctrl_a[`TMR_CA_LVL_A];
    if (period_start)
      next_st.out_a = st.ctrl_a[`TMR_CA_LVL_B];
    // level B on its own pin
    if ((match_b && (mode == tmr_pkg::TMR_MODE_CMP)) ||
        st.ctrl_a[`TMR_CA_FORCE_B])
      next_st.out_b = st.ctrl_a[`TMR_CA_LVL_B];

    next_st.wr_pend = addr_ok && hwrite;
    next_st.wr_idx  = idx;
    if (rd_go)
      next_st.rdata = rd_mux(idx);

    if (st.wr_pend)
    begin
      case (st.wr_idx)
        `TMR_IDX_CTRL_A:  next_st.ctrl_a = wbyte;
        `TMR_IDX_CTRL_B:  next_st.ctrl_b = wbyte;
        `TMR_IDX_STATUS:  next_st.freeze = wbyte[`TMR_ST_FREEZE];
        `TMR_IDX_CMPA_HI: next_st.cmp_a[15:8] = wbyte;
        `TMR_IDX_CMPA_LO: next_st.cmp_a[7:0] = wbyte;
        `TMR_IDX_CMPB_HI: next_st.cmp_b[15:8] = wbyte;
        `TMR_IDX_CMPB_LO: next_st.cmp_b[7:0] = wbyte;
        default:          next_st.wr_idx = st.wr_idx;
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      st <= ST_RESET;
    else
      st <= next_st;
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = {24'h000000, st.rdata};

  assign compare_out_a    = st.out_a;
  assign compare_out_a_en = st.ctrl_b[`TMR_CB_PIN_A] && !st.freeze;
  assign compare_out_b    = st.out_b;
  assign compare_out_b_en = st.ctrl_b[`TMR_CB_PIN_B] && !st.freeze;

  assign irq_pend =
    (st.ctrl_a[`TMR_CA_CAP_IE] &&
     (st.flags[`TMR_FLAG_CAP_A] || st.flags[`TMR_FLAG_CAP_B])) ||
    (st.ctrl_a[`TMR_CA_CMP_IE] &&
     (st.flags[`TMR_FLAG_CMP_A] || st.flags[`TMR_FLAG_CMP_B])) ||
    (st.ctrl_a[`TMR_CA_OVF_IE] && st.flags[`TMR_FLAG_OVF]);
  assign timer_irq = irq_pend && !cpu_irq_mask;
  assign wake_req  = timer_irq && !halt_mode;

  //////////////////////////////////////////////////////////////////////////
  // Checks

  irq_gate_a:
    assert property (@(posedge clock) disable iff (!reset_n)
      timer_irq |-> !cpu_irq_mask && irq_pend)
    else $error("interrupt raised while masked or with no cause");

  halt_wake_a:
    assert property (@(posedge clock) disable iff (!reset_n)
      (halt_mode |-> !wake_req) and (timer_irq && !halt_mode |-> wake_req))
    else $error("wake request wrong for halt or wait");

  cap_irq_a:
    assert property (@(posedge clock) disable iff (!reset_n)
      (st.ctrl_a[`TMR_CA_CAP_IE] && st.flags[`TMR_FLAG_CAP_B] &&
       !cpu_irq_mask) |-> timer_irq)
    else $error("capture B flag did not raise interrupt");

  cmp_out_a:
    assert property (@(posedge clock) disable iff (!reset_n)
      (mode == tmr_pkg::TMR_MODE_CMP && match_a) |=>
        st.out_a == $past(st.ctrl_a[`TMR_CA_LVL_A]))
    else $error("compare A match did not drive level A");

  ovf_set_a:
    assert property (@(posedge clock) disable iff (!reset_n)
      (ovf_ev && !cnt_wr && !period_start) |=>
        st.flags[`TMR_FLAG_OVF] && st.count == 16'h0000)
    else $error("wrap did not set overflow flag");

  freeze_hold_a:
    assert property (@(posedge clock) disable iff (!reset_n)
      (st.freeze && next_st.freeze && !cnt_wr && !period_start) |=>
        $stable(st.count) && !compare_out_a_en && !compare_out_b_en)
    else $error("counter moved or pin driven while frozen");

  pwm_noflag_a:
    assert property (@(posedge clock) disable iff (!reset_n)
      (mode == tmr_pkg::TMR_MODE_PWM && !st.flags[`TMR_FLAG_CMP_A] &&
       !st.flags[`TMR_FLAG_CMP_B]) |=>
        !st.flags[`TMR_FLAG_CMP_A] && !st.flags[`TMR_FLAG_CMP_B])
    else $error("compare flag set in PWM mode");

  pwm_reload_a:
    assert property (@(posedge clock) disable iff (!reset_n)
      (mode == tmr_pkg::TMR_MODE_PWM && match_b) |=>
        st.count == `TMR_CNT_RESET && st.flags[`TMR_FLAG_CAP_A])
    else $error("PWM period end did not reload counter");

  cnt_reset_a:
    assert property (@(posedge clock) disable iff (!reset_n)
      cnt_wr |=> st.count == `TMR_CNT_RESET)
    else $error("counter low write did not reset counter");

  clr_keep_a:
    assert property (@(posedge clock) disable iff (!reset_n)
      (st.flags[`TMR_FLAG_OVF] && !st.armed[`TMR_FLAG_OVF]) |=>
        st.flags[`TMR_FLAG_OVF])
    else $error("unarmed overflow flag was cleared");
endmodule

//--- tmr_pins.sv
// Purpose: Pin-side model for the capture, count-clock and compare pins
// Assumes: Its tasks are called right after a rising clock edge
// Notes:   A compare pin that the timer releases reads its pull-up level
`timescale 1ns/1ps
module tmr_pins
(
  input  wire logic clock,
  input  wire logic compare_out_a,
  input  wire logic compare_out_a_en,
  input  wire logic compare_out_b,
  input  wire logic compare_out_b_en,
  output logic      capture_in_a,
  output logic      capture_in_b,
  output logic      ext_count_clock,
  output logic      pin_a,
  output logic      pin_b
);
  // A freed pin must not keep showing the stale timer level
  assign pin_a = compare_out_a_en ? compare_out_a : 1'b1;
  assign pin_b = compare_out_b_en ? compare_out_b : 1'b1;

  initial
  begin
    capture_in_a    = 1'b0;
    capture_in_b    = 1'b0;
    ext_count_clock = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic set_cap(input logic b, input logic v);
    @(posedge clock);
    if (b)
      capture_in_b <= v;
    else
      capture_in_a <= v;
  endtask

  // Count clock stands still between bursts
  task automatic ext_toggle(input int n);
    repeat (n)
    begin
      @(posedge clock);
      ext_count_clock <= ~ext_count_clock;
      @(posedge clock);
    end
  endtask
endmodule

//--- tmr_ctrl_test.sv
// Purpose: Self-checking bench of the timer control block
// Assumes: Zero-wait bus; external pins come from the pin model
// Notes:   Divided rates get one tick of slack for the divider phase
`timescale 1ns/1ps
`include "tmr_defines.svh"
module tmr_ctrl_test;
  localparam logic [7:0] ST  = `TMR_IDX_STATUS;
  localparam logic [7:0] CTA = `TMR_IDX_CTRL_A;
  localparam logic [7:0] CTB = `TMR_IDX_CTRL_B;
  logic        clock;
  logic        reset_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hready;
  logic [31:0] hrdata;
  logic        hresp;
  logic        cap_a;
  logic        cap_b;
  logic        ext_clk;
  logic        irq_mask;
  logic        halt;
  logic        out_a;
  logic        out_a_en;
  logic        out_b;
  logic        out_b_en;
  logic        irq;
  logic        wake;
  logic        pin_a;
  logic        pin_b;
  logic [7:0]  rv;
  int          errors = 0;
  int          n_checks = 0;
  int          cyc = 0;

  tmr_ctrl u_tmr_ctrl
  (
    .clock            (clock),
    .reset_n          (reset_n),
    .hsel             (hsel),
    .haddr            (haddr),
    .htrans           (htrans),
    .hwrite           (hwrite),
    .hsize            (3'b010),
    .hwdata           (hwdata),
    .hready           (hready),
    .hreadyout        (hready),
    .hresp            (hresp),
    .hrdata           (hrdata),
    .capture_in_a     (cap_a),
    .capture_in_b     (cap_b),
    .ext_count_clock  (ext_clk),
    .cpu_irq_mask     (irq_mask),
    .halt_mode        (halt),
    .compare_out_a    (out_a),
    .compare_out_a_en (out_a_en),
    .compare_out_b    (out_b),
    .compare_out_b_en (out_b_en),
    .timer_irq        (irq),
    .wake_req         (wake)
  );

  tmr_pins u_tmr_pins
  (
    .clock            (clock),
    .compare_out_a    (out_a),
    .compare_out_a_en (out_a_en),
    .compare_out_b    (out_b),
    .compare_out_b_en (out_b_en),
    .capture_in_a     (cap_a),
    .capture_in_b     (cap_b),
    .ext_count_clock  (ext_clk),
    .pin_a            (pin_a),
    .pin_b            (pin_b)
  );
  //////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] s,
                     input logic [15:0] e);
    n_checks++;
    if (s !== e)
    begin
      errors++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask

  task automatic wt(input int n);
    repeat (n)
      @(posedge clock);
  endtask

  // One idle cycle follows every transfer, as the slave needs
  task automatic bus(input logic w, input logic [7:0] i,
                     input logic [7:0] d);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {22'h0, i, 2'b00};
    @(posedge clock);
    while (hready !== 1'b1)
      @(posedge clock);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= {24'h0, d};
    @(posedge clock);
    while (hready !== 1'b1)
      @(posedge clock);
    rv = hrdata[7:0];
    @(posedge clock);
  endtask

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    bus(1'b1, i, d);
  endtask

  task automatic rc(input string nm, input logic [7:0] i,
                    input logic [7:0] m, input logic [7:0] e);
    bus(1'b0, i, 8'h00);
    chk(nm, 16'(rv & m), 16'(e));
  endtask

  task automatic frz(input logic f);
    wr(ST, {5'h00, f, 2'b00});
  endtask

  // Status read then every low byte, so all flags start clear
  task automatic clr();
    bus(1'b0, ST, 8'h00);
    bus(1'b0, `TMR_IDX_CAPA_LO, 8'h00);
    bus(1'b0, `TMR_IDX_CMPA_LO, 8'h00);
    bus(1'b0, `TMR_IDX_CNT_LO, 8'h00);
    bus(1'b0, `TMR_IDX_CAPB_LO, 8'h00);
    bus(1'b0, `TMR_IDX_CMPB_LO, 8'h00);
  endtask

  // Sampled on the falling edge so no update races the read
  task automatic meas(input int n, output int r, output int h);
    logic p;
    r = 0;
    h = 0;
    p = pin_a;
    repeat (n)
    begin
      @(negedge clock);
      r += int'(pin_a && !p);
      h += int'(pin_a);
      p = pin_a;
    end
    @(posedge clock);
  endtask

  task automatic t_reset();
    rc("cnt_lo", `TMR_IDX_CNT_LO, 8'hFC, 8'hFC);
    rc("status", ST, 8'hFF, 8'h00);
    rc("cnt_hi", `TMR_IDX_CNT_HI, 8'hFF, 8'hFF);
    rc("ctrl_a", CTA, 8'hFF, 8'h00);
    rc("ctrl_b", CTB, 8'hFF, 8'h00);
    rc("cmpa_hi", `TMR_IDX_CMPA_HI, 8'hFF, 8'h80);
    rc("unmapped", 8'h20, 8'hFF, 8'h00);
    wr(CTA, 8'h5A);
    rc("ctrl_a rw", CTA, 8'hFF, 8'h5A);
    wr(CTA, 8'h00);
    wr(`TMR_IDX_CAPA_HI, 8'h55);
    rc("capa_hi ro", `TMR_IDX_CAPA_HI, 8'hFF, 8'h00);
    wr(ST, 8'hFB);
    rc("status wr", ST, 8'h07, 8'h00);
    frz(1'b1);
    rc("freeze", ST, 8'h07, 8'h04);
    chk("hresp", 16'(hresp), 16'h0);
  endtask

  task automatic t_clk();
    logic [7:0] d [5] = '{8'h0C, 8'h1C, 8'h04, 8'hFE, 8'hFE};
    logic [7:0] sl;
    for (int s = 0; s < 5; s++)
    begin
      wr(CTB, {4'h0, 2'((s > 2) ? 3 : s), 1'b0, 1'(s == 3)});
      wr(`TMR_IDX_CNT_LO, 8'h00);
      frz(1'b0);
      if (s < 3)
        wt(61);
      else
        u_tmr_pins.ext_toggle(3);
      frz(1'b1);
      bus(1'b0, `TMR_IDX_CNT_LO, 8'h00);
      sl = (s < 3) ? 8'h01 : 8'h00;
      chk("count", 16'(8'(rv - d[s] + sl) <= 2 * sl), 16'h1);
    end
    wr(CTB, 8'h04);
    wt(20);
    rc("frozen", `TMR_IDX_CNT_LO, 8'hFF, 8'hFE);
  endtask

  task automatic t_ovf();
    wr(CTB, 8'h00);
    wr(CTA, 8'h20);
    wr(`TMR_IDX_CNT_LO, 8'h00);
    clr();
    chk("irq idle", 16'(irq), 16'h0);
    frz(1'b0);
    wt(30);
    rc("ovf", ST, 8'h20, 8'h20);
    chk("irq", 16'({irq, wake}), 16'h3);
    irq_mask <= 1'b1;
    wt(1);
    chk("irq masked", 16'({irq, wake}), 16'h0);
    irq_mask <= 1'b0;
    halt     <= 1'b1;
    wt(1);
    chk("halt", 16'({irq, wake}), 16'h2);
    halt <= 1'b0;
    wr(CTA, 8'h00);
    chk("irq inhibit", 16'(irq), 16'h0);
    bus(1'b0, `TMR_IDX_ALT_LO, 8'h00);
    rc("alt keeps", ST, 8'h20, 8'h20);
    bus(1'b0, `TMR_IDX_CNT_LO, 8'h00);
    rc("ovf clear", ST, 8'h20, 8'h00);
  endtask

  task automatic t_cap();
    logic [7:0] m;
    logic [7:0] lo;
    for (int p = 0; p < 2; p++)
      for (int e = 0; e < 2; e++)
      begin
        m  = p ? 8'h10 : 8'h80;
        lo = p ? `TMR_IDX_CAPB_LO : `TMR_IDX_CAPA_LO;
        wr(CTA, {1'b1, 5'h00, e[0], 1'b0});
        wr(CTB, {6'h00, e[0], 1'b0});
        u_tmr_pins.set_cap(p[0], e[0]);
        wt(2);
        clr();
        u_tmr_pins.set_cap(p[0], !e[0]);
        wt(2);
        rc("wrong edge", ST, m, 8'h00);
        chk("irq none", 16'(irq), 16'h0);
        u_tmr_pins.set_cap(p[0], e[0]);
        wt(2);
        rc("cap flag", ST, m, m);
        chk("cap irq", 16'(irq), 16'h1);
        bus(1'b0, lo, 8'h00);
        rc("cap clear", ST, m, 8'h00);
        u_tmr_pins.set_cap(p[0], !e[0]);
        u_tmr_pins.set_cap(p[0], e[0]);
        wt(2);
        bus(1'b0, lo, 8'h00);
        rc("late flag", ST, m, m);
      end
  endtask

  task automatic t_cmp();
    frz(1'b1);
    wr(CTB, 8'hC4);
    wr(CTA, 8'h45);
    wr(`TMR_IDX_CMPA_HI, 8'h00);
    wr(`TMR_IDX_CMPA_LO, 8'h10);
    wr(`TMR_IDX_CMPB_HI, 8'h00);
    wr(`TMR_IDX_CMPB_LO, 8'h20);
    wr(`TMR_IDX_CNT_LO, 8'h00);
    clr();
    frz(1'b0);
    chk("pins idle", 16'({out_a_en, out_b_en, pin_a, pin_b}), 16'hC);
    wt(20);
    rc("no match", ST, 8'h48, 8'h00);
    wt(40);
    chk("match a", 16'({pin_a, pin_b, irq}), 16'h5);
    wt(30);
    rc("cmp flags", ST, 8'h48, 8'h48);
    chk("match b", 16'(pin_b), 16'h1);
    wr(CTB, 8'h84);
    chk("pin b free", 16'({out_b_en, pin_b}), 16'h1);
    wr(CTB, 8'hC4);
    wr(CTA, 8'h18);
    wt(1);
    chk("force low", 16'({pin_a, pin_b}), 16'h0);
    wr(CTA, 8'h1D);
    wt(1);
    chk("force high", 16'({pin_a, pin_b}), 16'h3);
    frz(1'b1);
    chk("freeze pins", 16'({out_a_en, out_b_en}), 16'h0);
  endtask

  task automatic t_pwm();
    int r;
    int h;
    wr(CTA, 8'h04);
    wr(CTB, 8'hB4);
    wr(`TMR_IDX_CMPA_LO, 8'h04);
    wr(`TMR_IDX_CMPB_LO, 8'h10);
    wr(`TMR_IDX_CNT_LO, 8'h00);
    clr();
    frz(1'b0);
    meas(400, r, h);
    chk("pwm periods", 16'(r inside {[9:11]}), 16'h1);
    chk("pwm high", 16'(h inside {[140:180]}), 16'h1);
    rc("pwm flags", ST, 8'hC8, 8'h80);
  endtask

  task automatic t_pulse();
    int r;
    int h;
    wr(CTB, 8'hA4);
    wr(CTA, 8'h08);
    wr(CTA, 8'h06);
    wr(`TMR_IDX_CMPA_LO, 8'h08);
    u_tmr_pins.set_cap(1'b0, 1'b0);
    wt(30);
    chk("no trigger", 16'(pin_a), 16'h0);
    u_tmr_pins.set_cap(1'b0, 1'b1);
    meas(150, r, h);
    chk("one pulse", 16'(r), 16'h1);
    chk("pulse len", 16'(h inside {[20:28]}), 16'h1);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // A hung wait ends the run as a mismatch
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 10000)
    begin
      errors++;
      end_sim();
    end
  end

  initial
  begin
    reset_n  = 1'b0;
    hsel     = 1'b0;
    haddr    = 32'h0;
    htrans   = 2'b00;
    hwrite   = 1'b0;
    hwdata   = 32'h0;
    irq_mask = 1'b0;
    halt     = 1'b0;
    wt(2);
    reset_n <= 1'b1;
    wt(1);
    t_reset();
    t_clk();
    t_ovf();
    t_cap();
    t_cmp();
    t_pwm();
    t_pulse();
    end_sim();
  end
endmodule
